// file: verilog/dma_pkg.sv
package dma_pkg;
   // =====================================================
   // register indices (byte address is four times the index)
   localparam logic [7:0] IDX_D0_SRC_LO = 8'hc0;
   localparam logic [7:0] IDX_D0_SRC_HI = 8'hc2;
   localparam logic [7:0] IDX_D0_DST_LO = 8'hc4;
   localparam logic [7:0] IDX_D0_DST_HI = 8'hc6;
   localparam logic [7:0] IDX_D0_COUNT  = 8'hc8;
   localparam logic [7:0] IDX_D0_CTRL   = 8'hca;
   localparam logic [7:0] IDX_D1_SRC_LO = 8'hd0;
   localparam logic [7:0] IDX_D1_SRC_HI = 8'hd2;
   localparam logic [7:0] IDX_D1_DST_LO = 8'hd4;
   localparam logic [7:0] IDX_D1_DST_HI = 8'hd6;
   localparam logic [7:0] IDX_D1_COUNT  = 8'hd8;
   localparam logic [7:0] IDX_D1_CTRL   = 8'hda;
   // =====================================================
   // register select codes inside one channel (index bits 3:1)
   localparam logic [2:0] SEL_SRC_LO = 3'h0;
   localparam logic [2:0] SEL_SRC_HI = 3'h1;
   localparam logic [2:0] SEL_DST_LO = 3'h2;
   localparam logic [2:0] SEL_DST_HI = 3'h3;
   localparam logic [2:0] SEL_COUNT  = 3'h4;
   localparam logic [2:0] SEL_CTRL   = 3'h5;
   // =====================================================
   // control field positions
   localparam int DEST_SPACE_SELECT   = 15;
   localparam int DEST_STEP_DOWN      = 14;
   localparam int DEST_STEP_UP        = 13;
   localparam int SOURCE_SPACE_SELECT = 12;
   localparam int SOURCE_STEP_DOWN    = 11;
   localparam int SOURCE_STEP_UP      = 10;
   localparam int COUNT_END_STOP      = 9;
   localparam int DONE_IRQ_ENABLE     = 8;
   localparam int PACING_SELECT_HI    = 7;
   localparam int PACING_SELECT_LO    = 6;
   localparam int CHANNEL_PRIORITY    = 5;
   localparam int TIMER_PACING_ENABLE = 4;
   localparam int PIN_AS_IRQ          = 3;
   localparam int RUN_WRITE_GATE      = 2;
   localparam int CHANNEL_RUN         = 1;
   localparam int WORD_SIZE_SELECT    = 0;
   // =====================================================
   // pacing codes and reset values
   localparam logic [1:0]  PACE_FREE     = 2'b00;
   localparam logic [1:0]  PACE_SOURCE   = 2'b01;
   localparam logic [1:0]  PACE_DEST     = 2'b10;
   localparam logic [1:0]  PACE_RESERVED = 2'b11;
   localparam logic [15:0] CTRL_RESET    = 16'h00c0;
   localparam logic [15:0] REG_RESET     = 16'h0000;
   localparam int          HI_BITS       = 4;
   localparam int          SYNC_STAGES   = 2;
   // =====================================================
   // transfer sequencer states, gray order along the path
   typedef enum logic [1:0] {
      XFER_IDLE    = 2'b00,
      XFER_FETCH   = 2'b01,
      XFER_DEPOSIT = 2'b11,
      XFER_STEP    = 2'b10
   } xfer_state_t;
endpackage : dma_pkg

// file: verilog/dma_sync2.sv
`timescale 1ns/100ps
// =====================================================
// two-stage synchroniser for pin levels
module dma_sync2 #(
   parameter int W = 2
) (
   input  wire logic         i_sys_clk,
   input  wire logic         i_rst_b,
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);
   logic [W-1:0] meta_q;

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         meta_q <= '0;
         o_sync <= '0;
      end else begin
         meta_q <= i_async;
         o_sync <= meta_q;
      end
   end
endmodule : dma_sync2

// file: verilog/dma_controller.sv
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/100ps
// Functional notes
// - destination space bit 15: one selects memory, zero selects I/O.
// - source space bit 12: one selects memory, zero selects I/O.
// - destination steps down or up per bits 14/13; equal bits hold it.
// - pointers step independently, by two for words, one for bytes.
// - source bits 11/10 step the source pointer the same way.
// - count decrements after every transfer regardless of terminal-count bit.
// - free-running stops at zero; paced stops at zero only with bit 9.
// - completion interrupt needs both interrupt bit 8 and terminal-count bit.
// - pacing field 7-6 decode; ignored while timer pacing is enabled.
// - reset forces the pacing field to 11b.
// - simultaneous requests go to the channel with priority bit 5 set.
// - timer 2 requests accepted only while bit 4 is one.
// - bit 3 routes request pin to interrupt controller; channel ignores it.
// - run bit changes only with bit 2 set in same write; bit 2 reads zero.
// - writing run bit 1 starts the channel; reset clears it.
// - bit 0 selects word transfers; narrow bus forces bytes.
// - 20-bit pointer is the 4-bit high field above the 16-bit low register.
// - fetch drives source high bits on 19-16, low bits on 15-0.
// - deposit drives destination high bits on 19-16.
module dma_controller (
   input  wire logic        i_sys_clk,
   input  wire logic        i_rst_b,
   // ahb-lite slave
   input  wire logic        i_hsel,
   input  wire logic [31:0] i_haddr,
   input  wire logic [1:0]  i_htrans,
   input  wire logic        i_hwrite,
   input  wire logic [2:0]  i_hsize,
   input  wire logic [31:0] i_hwdata,
   input  wire logic        i_hready,
   output logic      [31:0] o_hrdata,
   output logic             o_hreadyout,
   output logic             o_hresp,
   // request sources
   input  wire logic [1:0]  i_drq,
   input  wire logic        i_timer2_req,
   input  wire logic        i_narrow_bus,
   output logic      [1:0]  o_pin_irq,
   output logic      [1:0]  o_done_irq,
   // system bus master
   output logic             o_bus_req,
   output logic      [19:0] o_bus_addr,
   output logic             o_bus_write,
   output logic             o_bus_mem,
   output logic             o_bus_word,
   output logic      [15:0] o_bus_wdata,
   input  wire logic        i_bus_ack,
   input  wire logic [15:0] i_bus_rdata
);
   // =====================================================
   // decoding helpers
   // returns {hit, channel, select}
   function automatic logic [4:0] reg_decode(input logic [31:0] addr);
      logic [7:0] idx;
      logic       ok;
      idx = addr[9:2];
      ok  = (addr[31:10] == 22'h0) && (addr[1:0] == 2'h0) && !idx[0]
            && (idx[3:1] <= dma_pkg::SEL_CTRL)
            && ((idx[7:4] == dma_pkg::IDX_D0_SRC_LO[7:4])
                || (idx[7:4] == dma_pkg::IDX_D1_SRC_LO[7:4]));
      reg_decode = {ok, idx[4], idx[3:1]};
   endfunction : reg_decode

   function automatic logic [19:0] ptr_step(input logic [19:0] ptr,
                                            input logic up,
                                            input logic down,
                                            input logic word);
      logic [19:0] amt;
      amt = word ? 20'h00002 : 20'h00001;
      if (up && !down) begin
         ptr_step = ptr + amt;
      end else if (down && !up) begin
         ptr_step = ptr - amt;
      end else begin
         ptr_step = ptr;
      end
   endfunction : ptr_step

   // =====================================================
   // storage
   logic [15:0] src_lo_q [2];
   logic [3:0]  src_hi_q [2];
   logic [15:0] dst_lo_q [2];
   logic [3:0]  dst_hi_q [2];
   logic [15:0] count_q  [2];
   logic [15:0] ctrl_q   [2];

   // sequencer state and the word held between fetch and deposit
   dma_pkg::xfer_state_t state_q;
   logic        act_q;
   logic [15:0] data_q;
   logic [1:0]  drq_s;
   logic [1:0]  want;
   logic        pick;
   // registered address phase of the register slave
   logic        wr_q;
   logic        wr_ch_q;
   logic [2:0]  wr_sel_q;
   logic        rd_q;
   logic [4:0]  rd_dec_q;
   // decode of the address phase now on the bus
   logic [4:0]  dec;
   logic        addr_ok;

   // pins come from outside, so they cross two flops first
   dma_sync2 #(
      .W(2)
   ) u_drq_sync (
      .i_sys_clk(i_sys_clk),
      .i_rst_b  (i_rst_b),
      .i_async  (i_drq),
      .o_sync   (drq_s)
   );

   // =====================================================
   // bus slave address phase
   assign dec     = reg_decode(i_haddr);
   assign addr_ok = i_hsel && i_htrans[1] && i_hready;

   // writes land one edge after their address phase, with no wait state
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         wr_q     <= 1'b0;
         wr_ch_q  <= 1'b0;
         wr_sel_q <= 3'h0;
         rd_q     <= 1'b0;
         rd_dec_q <= 5'h00;
      end else begin
         wr_q     <= addr_ok && i_hwrite && dec[4];
         wr_ch_q  <= dec[3];
         wr_sel_q <= dec[2:0];
         rd_q     <= addr_ok && !i_hwrite;
         rd_dec_q <= dec;
      end
   end

   // reads take one wait state so a write just ahead is already stored
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_hreadyout <= 1'b1;
         o_hrdata    <= 32'h00000000;
      end else if (addr_ok && !i_hwrite) begin
         o_hreadyout <= 1'b0;
      end else if (rd_q) begin
         o_hreadyout <= 1'b1;
         o_hrdata    <= 32'h00000000;
         if (rd_dec_q[4]) begin
            unique case (rd_dec_q[2:0])
               dma_pkg::SEL_SRC_LO: o_hrdata[15:0] <= src_lo_q[rd_dec_q[3]];
               dma_pkg::SEL_SRC_HI: o_hrdata[3:0]  <= src_hi_q[rd_dec_q[3]];
               dma_pkg::SEL_DST_LO: o_hrdata[15:0] <= dst_lo_q[rd_dec_q[3]];
               dma_pkg::SEL_DST_HI: o_hrdata[3:0]  <= dst_hi_q[rd_dec_q[3]];
               dma_pkg::SEL_COUNT:  o_hrdata[15:0] <= count_q[rd_dec_q[3]];
               default:             o_hrdata[15:0] <= ctrl_q[rd_dec_q[3]];
            endcase
         end
      end
   end

   // no access is ever refused, so the response stays okay
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_hresp <= 1'b0;
      end else begin
         o_hresp <= 1'b0;
      end
   end

   // =====================================================
   // per channel request qualification and registers
   for (genvar ch = 0; ch < 2; ch++) begin : g_ch
      logic [15:0] c;
      logic [15:0] cnt_nxt;
      logic        free_run;
      logic        stepping;
      logic        sw_wr;
      logic        stop;
      logic        pin_req;

      // free_run decides whether a zero count always ends the run
      assign c        = ctrl_q[ch];
      assign cnt_nxt  = count_q[ch] - 16'h0001;
      assign free_run = !c[dma_pkg::TIMER_PACING_ENABLE]
                        && (c[7:6] == dma_pkg::PACE_FREE);
      assign stepping = (state_q == dma_pkg::XFER_STEP) && (act_q == ch);
      assign sw_wr    = wr_q && (wr_ch_q == ch);
      assign stop     = (cnt_nxt == 16'h0000)
                        && (free_run || c[dma_pkg::COUNT_END_STOP]);
      assign pin_req  = drq_s[ch] && !c[dma_pkg::PIN_AS_IRQ];

      // with timer pacing off, the reserved pacing code never asks for the bus
      always_comb begin
         if (!c[dma_pkg::CHANNEL_RUN]) begin
            want[ch] = 1'b0;
         end else if (c[dma_pkg::TIMER_PACING_ENABLE]) begin
            want[ch] = i_timer2_req;
         end else begin
            unique case (c[7:6])
               dma_pkg::PACE_FREE:     want[ch] = 1'b1;
               dma_pkg::PACE_SOURCE:   want[ch] = pin_req;
               dma_pkg::PACE_DEST:     want[ch] = pin_req;
               dma_pkg::PACE_RESERVED: want[ch] = 1'b0;
            endcase
         end
      end

      // pointers; reset clears them to zero before software loads them
      always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
         if (!i_rst_b) begin
            src_lo_q[ch] <= dma_pkg::REG_RESET;
            src_hi_q[ch] <= 4'h0;
            dst_lo_q[ch] <= dma_pkg::REG_RESET;
            dst_hi_q[ch] <= 4'h0;
         end else if (sw_wr && (wr_sel_q == dma_pkg::SEL_SRC_LO)) begin
            src_lo_q[ch] <= i_hwdata[15:0];
         end else if (sw_wr && (wr_sel_q == dma_pkg::SEL_SRC_HI)) begin
            src_hi_q[ch] <= i_hwdata[3:0];
         end else if (sw_wr && (wr_sel_q == dma_pkg::SEL_DST_LO)) begin
            dst_lo_q[ch] <= i_hwdata[15:0];
         end else if (sw_wr && (wr_sel_q == dma_pkg::SEL_DST_HI)) begin
            dst_hi_q[ch] <= i_hwdata[3:0];
         end else if (stepping) begin
            {src_hi_q[ch], src_lo_q[ch]} <= ptr_step({src_hi_q[ch], src_lo_q[ch]},
               c[dma_pkg::SOURCE_STEP_UP], c[dma_pkg::SOURCE_STEP_DOWN],
               o_bus_word);
            {dst_hi_q[ch], dst_lo_q[ch]} <= ptr_step({dst_hi_q[ch], dst_lo_q[ch]},
               c[dma_pkg::DEST_STEP_UP], c[dma_pkg::DEST_STEP_DOWN],
               o_bus_word);
         end
      end

      // in a paced run, a zero count with the end-stop bit clear wraps to all ones
      always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
         if (!i_rst_b) begin
            count_q[ch] <= dma_pkg::REG_RESET;
         end else if (sw_wr && (wr_sel_q == dma_pkg::SEL_COUNT)) begin
            count_q[ch] <= i_hwdata[15:0];
         end else if (stepping) begin
            count_q[ch] <= cnt_nxt;
         end
      end

      // a software write wins over the completion stop in the same cycle
      always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
         if (!i_rst_b) begin
            ctrl_q[ch] <= dma_pkg::CTRL_RESET;
         end else if (sw_wr && (wr_sel_q == dma_pkg::SEL_CTRL)) begin
            ctrl_q[ch] <= {i_hwdata[15:3], 1'b0,
                           i_hwdata[dma_pkg::RUN_WRITE_GATE]
                              ? i_hwdata[dma_pkg::CHANNEL_RUN]
                              : c[dma_pkg::CHANNEL_RUN],
                           i_hwdata[0]};
         end else if (stepping && stop) begin
            ctrl_q[ch][dma_pkg::CHANNEL_RUN] <= 1'b0;
         end
      end

      // done pulse lasts one cycle, the cycle after the step
      always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
         if (!i_rst_b) begin
            o_done_irq[ch] <= 1'b0;
            o_pin_irq[ch]  <= 1'b0;
         end else begin
            o_done_irq[ch] <= stepping && (cnt_nxt == 16'h0000)
                              && c[dma_pkg::DONE_IRQ_ENABLE]
                              && c[dma_pkg::COUNT_END_STOP];
            o_pin_irq[ch]  <= drq_s[ch] && c[dma_pkg::PIN_AS_IRQ];
         end
      end
   end

   // =====================================================
   // arbitration: a tie on the priority bit falls to channel 0
   // pick is looked at only in idle; a late request waits for the next slot
   always_comb begin
      if (want[0] && want[1]) begin
         pick = ctrl_q[1][dma_pkg::CHANNEL_PRIORITY]
                && !ctrl_q[0][dma_pkg::CHANNEL_PRIORITY];
      end else begin
         pick = want[1];
      end
   end

   // =====================================================
   // transfer sequencer and bus master
   // o_bus_req stays high from fetch through deposit, so the pair is never split
   // the narrow-bus level is taken once at start so both halves agree on size
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_q     <= dma_pkg::XFER_IDLE;
         act_q       <= 1'b0;
         data_q      <= 16'h0000;
         o_bus_req   <= 1'b0;
         o_bus_addr  <= 20'h00000;
         o_bus_write <= 1'b0;
         o_bus_mem   <= 1'b0;
         o_bus_word  <= 1'b0;
         o_bus_wdata <= 16'h0000;
      end else begin
         unique case (state_q)
            dma_pkg::XFER_IDLE: begin
               if (|want) begin
                  state_q     <= dma_pkg::XFER_FETCH;
                  act_q       <= pick;
                  o_bus_req   <= 1'b1;
                  o_bus_write <= 1'b0;
                  o_bus_addr  <= {src_hi_q[pick], src_lo_q[pick]};
                  o_bus_mem   <= ctrl_q[pick][dma_pkg::SOURCE_SPACE_SELECT];
                  o_bus_word  <= ctrl_q[pick][dma_pkg::WORD_SIZE_SELECT]
                                 && !i_narrow_bus;
               end
            end
            dma_pkg::XFER_FETCH: begin
               if (i_bus_ack) begin
                  state_q     <= dma_pkg::XFER_DEPOSIT;
                  data_q      <= i_bus_rdata;
                  o_bus_wdata <= i_bus_rdata;
                  o_bus_write <= 1'b1;
                  o_bus_addr  <= {dst_hi_q[act_q], dst_lo_q[act_q]};
                  o_bus_mem   <= ctrl_q[act_q][dma_pkg::DEST_SPACE_SELECT];
               end
            end
            dma_pkg::XFER_DEPOSIT: begin
               o_bus_wdata <= data_q;
               if (i_bus_ack) begin
                  state_q     <= dma_pkg::XFER_STEP;
                  o_bus_req   <= 1'b0;
                  o_bus_write <= 1'b0;
               end
            end
            dma_pkg::XFER_STEP: begin
               state_q <= dma_pkg::XFER_IDLE;
            end
         endcase
      end
   end
endmodule : dma_controller

// file: tb/dma_checker.sv
`timescale 1ns/100ps
// =====
// port-level checks of the register slave and the transfer sequencer
module dma_checker (
   input wire logic        i_sys_clk,
   input wire logic        i_rst_b,
   input wire logic        i_hsel,
   input wire logic [1:0]  i_htrans,
   input wire logic        i_hwrite,
   input wire logic        i_hready,
   input wire logic        o_hreadyout,
   input wire logic        i_narrow_bus,
   input wire logic [1:0]  o_done_irq,
   input wire logic        o_bus_req,
   input wire logic [19:0] o_bus_addr,
   input wire logic        o_bus_write,
   input wire logic        o_bus_mem,
   input wire logic        o_bus_word,
   input wire logic [15:0] o_bus_wdata,
   input wire logic        i_bus_ack,
   input wire logic [15:0] i_bus_rdata
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_b);
   read_wait_a: assert property (
      i_hsel && i_htrans[1] && !i_hwrite && i_hready |=> !o_hreadyout ##1 o_hreadyout)
      else $error("register read wait state wrong");
   write_nowait_a: assert property (
      i_hsel && i_htrans[1] && i_hwrite && i_hready |=> o_hreadyout)
      else $error("register write stalled");
   req_hold_a: assert property (
      o_bus_req && !i_bus_ack |=> o_bus_req && $stable(o_bus_addr) && $stable(o_bus_mem))
      else $error("bus cycle changed before ack");
   fetch_deposit_a: assert property (
      o_bus_req && !o_bus_write && i_bus_ack |=>
      o_bus_req && o_bus_write && o_bus_wdata == $past(i_bus_rdata))
      else $error("deposit does not carry fetched data");
   size_kept_a: assert property (
      o_bus_req && !o_bus_write && i_bus_ack |=> $stable(o_bus_word))
      else $error("size changed between fetch and deposit");
   deposit_end_a: assert property (
      o_bus_req && o_bus_write && i_bus_ack |=> !o_bus_req [*2])
      else $error("no step cycle after deposit");
   fetch_first_a: assert property ($rose(o_bus_req) |-> !o_bus_write)
      else $error("transfer did not begin with fetch");
   done_pulse_a: assert property (
      o_done_irq != 2'b00 |-> $past(o_bus_write, 2) && $past(i_bus_ack, 2)
      ##1 o_done_irq == 2'b00)
      else $error("done pulse misplaced");
   narrow_byte_a: assert property ($rose(o_bus_req) && $past(i_narrow_bus) |-> !o_bus_word)
      else $error("word cycle on narrow bus");
endmodule : dma_checker

bind dma_controller dma_checker u_dma_checker (
   .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_hsel(i_hsel), .i_htrans(i_htrans),
   .i_hwrite(i_hwrite), .i_hready(i_hready), .o_hreadyout(o_hreadyout),
   .i_narrow_bus(i_narrow_bus), .o_done_irq(o_done_irq), .o_bus_req(o_bus_req),
   .o_bus_addr(o_bus_addr), .o_bus_write(o_bus_write), .o_bus_mem(o_bus_mem),
   .o_bus_word(o_bus_word), .o_bus_wdata(o_bus_wdata), .i_bus_ack(i_bus_ack),
   .i_bus_rdata(i_bus_rdata));

// file: tb/dma_mem_model.sv
`timescale 1ns/100ps
// =====
// memory and i/o on the system bus, with a wait count set each cycle
module dma_mem_model (
   input wire logic        i_sys_clk,
   input wire logic        i_rst_b,
   input wire logic        i_req,
   input wire logic [19:0] i_addr,
   input wire logic [1:0]  i_lat,
   output logic            o_ack,
   output logic     [15:0] o_rdata
);
   logic [1:0]  wait_q;
   logic [15:0] junk_q;
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         wait_q <= 2'h0;
         junk_q <= 16'h0;
      end else begin
         junk_q <= junk_q + 16'h9e37;
         wait_q <= (o_ack || !i_req) ? 2'h0 : wait_q + 2'h1;
      end
   end
   assign o_ack = i_req && (wait_q >= i_lat);
   // data only valid with ack; otherwise churn so a late sample cannot pass
   assign o_rdata = o_ack ? (i_addr[15:0] ^ {12'h0, i_addr[19:16]} ^ 16'h5a5a) : junk_q;
endmodule : dma_mem_model

// file: tb/tb_two_channel_dma_controller.sv
`timescale 1ns/100ps
module tb_two_channel_dma_controller;
   logic clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, tmr = 1'b0;
   logic narrow = 1'b0, rd_phase = 1'b0, hreadyout, hresp, bus_req, bus_write;
   logic bus_mem, bus_word, bus_ack;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [1:0]  htrans = 2'h0, drq = 2'h0, lat = 2'h0, pin_irq, done_irq;
   logic [19:0] bus_addr;
   logic [15:0] bus_wdata, bus_rdata, c;
   logic [39:0] bus_q[$], rd_q[$];
   int n_errors = 0, total_checks = 0, irq_seen = 0, irq_exp = 0, n_bus = 0, tgt, n;
   always #2 clk = ~clk;
   always @(posedge clk) lat <= 2'($urandom);
   dma_controller u_dma_controller (.i_sys_clk(clk), .i_rst_b(rst_b), .i_hsel(hsel),
      .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
      .i_hwdata(hwdata), .i_hready(hreadyout), .o_hrdata(hrdata), .o_hreadyout(hreadyout),
      .o_hresp(hresp), .i_drq(drq), .i_timer2_req(tmr), .i_narrow_bus(narrow),
      .o_pin_irq(pin_irq), .o_done_irq(done_irq), .o_bus_req(bus_req),
      .o_bus_addr(bus_addr), .o_bus_write(bus_write), .o_bus_mem(bus_mem),
      .o_bus_word(bus_word), .o_bus_wdata(bus_wdata), .i_bus_ack(bus_ack),
      .i_bus_rdata(bus_rdata));
   dma_mem_model u_dma_mem_model (.i_sys_clk(clk), .i_rst_b(rst_b), .i_req(bus_req),
      .i_addr(bus_addr), .i_lat(lat), .o_ack(bus_ack), .o_rdata(bus_rdata));
   // =====
   // helpers
   task final_report;
      if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : final_report
   task check(input logic [39:0] seen, input logic [39:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task guard(input int k, input int lim);
      if (k >= lim) begin
         n_errors++;
         final_report();
      end
   endtask : guard
   function automatic logic [19:0] stp(logic [19:0] p, logic up, logic dn, logic w);
      if (up && !dn) return p + (w ? 20'h2 : 20'h1);
      if (dn && !up) return p - (w ? 20'h2 : 20'h1);
      return p;
   endfunction : stp
   // =====
   // ahb-lite master, single word transfers
   task ahb(input logic wr, input logic [31:0] a, input logic [15:0] d, input logic [15:0] e);
      int k;
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= wr;
      k = 0;
      do begin @(posedge clk); k++; end while (!hreadyout && k < 50);
      guard(k, 50);
      htrans <= 2'b00;
      hwdata <= {16'h0, d};
      rd_phase <= !wr;
      if (!wr) rd_q.push_back({24'h0, e});
      k = 0;
      do begin @(posedge clk); k++; end while (!hreadyout && k < 50);
      guard(k, 50);
      rd_phase <= 1'b0;
      hsel <= 1'b0;
   endtask : ahb
   task prog(input int ch, input logic [19:0] s, input logic [19:0] d,
             input logic [15:0] cnt, input logic [15:0] ctl);
      logic [31:0] b;
      b = {22'h0, dma_pkg::IDX_D0_SRC_LO, 2'b00} + 32'(ch) * 32'h40;
      ahb(1'b1, b, s[15:0], 16'h0);
      ahb(1'b1, b + 32'h8, {12'h0, s[19:16]}, 16'h0);
      ahb(1'b1, b + 32'h10, d[15:0], 16'h0);
      ahb(1'b1, b + 32'h18, {12'h0, d[19:16]}, 16'h0);
      ahb(1'b1, b + 32'h20, cnt, 16'h0);
      ahb(1'b1, b + 32'h28, ctl, 16'h0);
   endtask : prog
   // expected fetch/deposit pairs with pointers stepped after each
   task exp_run(input logic [15:0] ct, input logic [19:0] s, input logic [19:0] d,
                input int cnt, input logic nb);
      logic w;
      w = ct[0] && !nb;
      repeat (cnt) begin
         bus_q.push_back({2'b00, ct[12], w, s, 16'h0});
         bus_q.push_back({2'b01, ct[15], w, d, s[15:0] ^ {12'h0, s[19:16]} ^ 16'h5a5a});
         s = stp(s, ct[10], ct[11], w);
         d = stp(d, ct[13], ct[14], w);
      end
   endtask : exp_run
   task wait_bus(input int t);
      int k;
      k = 0;
      while (n_bus < t && k < 2000) begin @(posedge clk); k++; end
      guard(k, 2000);
   endtask : wait_bus
   // =====
   // result watcher: register reads and every acked bus cycle
   always @(posedge clk) begin
      if (rd_phase && hreadyout) check({7'h0, hresp, hrdata}, rd_q.pop_front());
      if (bus_req && bus_ack) begin
         n_bus++;
         check({1'b0, bus_write, bus_mem, bus_word, bus_addr, bus_write ? bus_wdata : 16'h0},
               bus_q.size() > 0 ? bus_q.pop_front() : 40'hff_ffff_ffff);
      end
      irq_seen += int'(done_irq[0]) + int'(done_irq[1]);
   end
   // =====
   // main sequence
   initial begin
      void'($urandom(79));
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      ahb(1'b0, 32'h328, 16'h0, 16'h00c0);
      ahb(1'b0, 32'h360, 16'h0, 16'h0000);
      ahb(1'b0, 32'h32c, 16'h0, 16'h0000);
      ahb(1'b1, 32'h328, 16'h0002, 16'h0);
      ahb(1'b0, 32'h328, 16'h0, 16'h0000);
      ahb(1'b1, 32'h348, 16'hffff, 16'h0);
      ahb(1'b0, 32'h348, 16'h0, 16'h000f);
      // free-running runs with random steps, spaces, sizes
      for (int k = 0; k < 6; k++) begin
         narrow <= (k == 5);
         c = (16'($urandom) & 16'hff01) | 16'h0006 | (k == 0 ? 16'h0300 : 16'h0);
         n = 1 + int'($urandom % 3);
         exp_run(c, 20'($urandom), 20'($urandom), n, k == 5);
         irq_exp += int'(c[8] & c[9]);
         tgt = n_bus + 2 * n;
         prog(k % 2, bus_q[0][35:16], bus_q[1][35:16], 16'(n), c);
         wait_bus(tgt);
         repeat (4) @(posedge clk);
         ahb(1'b0, 32'h320 + 32'(k % 2) * 32'h40, 16'h0, 16'h0);
         ahb(1'b0, 32'h328 + 32'(k % 2) * 32'h40, 16'h0, c & 16'hfff9);
      end
      // channel 1 source-paced and set to win, channel 0 destination-paced
      narrow <= 1'b0;
      exp_run(16'hb667, 20'h30000, 20'h40000, 2, 1'b0);
      exp_run(16'hb687, 20'h10000, 20'h20000, 2, 1'b0);
      prog(0, 20'h10000, 20'h20000, 16'h2, 16'hb687);
      prog(1, 20'h30000, 20'h40000, 16'h2, 16'hb667);
      tgt = n_bus + 8;
      drq <= 2'b11;
      wait_bus(tgt);
      check({38'h0, pin_irq}, 40'h0);
      drq <= 2'b00;
      repeat (4) @(posedge clk);
      ahb(1'b0, 32'h328, 16'h0, 16'hb681);
      // pin routed to interrupt: no transfer may start
      prog(0, 20'h10000, 20'h20000, 16'h1, 16'hb64f);
      drq <= 2'b01;
      repeat (6) @(posedge clk);
      check({38'h0, pin_irq}, 40'h1);
      drq <= 2'b00;
      ahb(1'b1, 32'h328, 16'h0004, 16'h0);
      // timer pacing, terminal count off: keeps going past zero
      exp_run(16'hb4d7, 20'h50000, 20'h60000, 3, 1'b0);
      prog(1, 20'h50000, 20'h60000, 16'h1, 16'hb4d7);
      repeat (3) begin
         tgt = n_bus + 2;
         @(posedge clk) tmr <= 1'b1;
         @(posedge clk) tmr <= 1'b0;
         wait_bus(tgt);
         repeat (4) @(posedge clk);
      end
      ahb(1'b0, 32'h360, 16'h0, 16'hfffe);
      ahb(1'b0, 32'h368, 16'h0, 16'hb4d3);
      ahb(1'b1, 32'h368, 16'hb4c7, 16'h0);
      @(posedge clk) tmr <= 1'b1;
      @(posedge clk) tmr <= 1'b0;
      repeat (10) @(posedge clk);
      ahb(1'b1, 32'h368, 16'hb4c4, 16'h0);
      check(40'(irq_seen), 40'(irq_exp));
      check(40'(bus_q.size()), 40'h0);
      final_report();
   end
endmodule : tb_two_channel_dma_controller
